/* verilog/fpf_pkg.sv */
package fpf_pkg;
	// apb register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00; // control: resets, dma enable
	localparam logic [7:0] ADDR_CFG = 8'h04; // mode bits, burst, fifo config
	localparam logic [7:0] ADDR_STAT = 8'h08; // main status, read only
	localparam logic [7:0] ADDR_DATA = 8'h0C; // command / data / result byte
	localparam logic [7:0] ADDR_CORE = 8'h10; // core-side controls
	// control register fields
	localparam int CTRL_HOLD_RST = 0; // held reset bit, set by pin reset
	localparam int CTRL_PULSE_RST = 1; // self-clearing reset bit
	localparam int CTRL_DMA_EN = 2; // dma enable
	// configuration fields
	localparam int CFG_BURST_N = 1; // 0 burst, 1 single
	localparam int CFG_ENC = 2; // encoding_mode_bit
	localparam int CFG_IDENT = 3; // identity bit
	localparam int CFG_FIFO_EN = 4; // fifo enable
	localparam int CFG_THR_LSB = 8; // fifo_threshold_field, 4 bits
	localparam int CFG_DMA_MODE = 12; // dma data transfers
	localparam logic [15:0] CFG_RESET = 16'h0002; // single transfer default
	// core control fields (start, direction, last sector, illegal, terminal, params)
	localparam int CORE_START = 0;
	localparam int CORE_READ = 1;
	localparam int CORE_LAST = 2;
	localparam int CORE_ILLEGAL = 3;
	localparam int CORE_DONE = 4;
	localparam int CORE_NPAR_LSB = 8; // parameter byte count, 4 bits
	localparam int CORE_NRES_LSB = 12; // result byte count, 4 bits
	localparam int FIFO_DEPTH = 16;
	localparam logic [4:0] FIFO_FULL_CNT = 5'h10;
	// controller phases
	typedef enum logic [3:0]
	{
		PH_CMD = 4'b0001,
		PH_EXEC = 4'b0010,
		PH_RES = 4'b0100,
		PH_RST = 4'b1000
	} fpf_phase_t;
	typedef enum logic [2:0]
	{
		MODE_AT = 3'b001,
		MODE_PS = 3'b010,
		MODE_M30 = 3'b100
	} fpf_mode_t;
endpackage

/* verilog/fpf_mem.sv */
`timescale 1ns/1ps
// 16 x 8 storage; read data registered
module fpf_mem
	import fpf_pkg::*;
(
	input wire logic clk,
	input wire logic we,
	input wire logic [3:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [3:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem_ff [FIFO_DEPTH]; // byte cells, no reset needed
	// write port
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem_ff[waddr] <= wdata;
		end
	end
	// registered read
	always_ff @(posedge clk)
	begin
		rdata <= mem_ff[raddr];
	end
endmodule // fpf_mem

/* verilog/fpf_fifo.sv */
`timescale 1ns/1ps
// 16-byte fifo; show-ahead via registered memory read one cycle later
module fpf_fifo
	import fpf_pkg::*;
(
	input wire logic clk,
	input wire logic clr, // synchronous flush
	input wire logic push,
	input wire logic [7:0] din,
	input wire logic pop,
	output logic [7:0] dout,
	output logic [4:0] count
);
	logic [3:0] wp_ff; // write pointer
	logic [3:0] rp_ff; // read pointer
	logic [4:0] cnt_ff; // occupancy
	logic do_push; // accepted push
	logic do_pop; // accepted pop
	assign do_push = push && (cnt_ff != FIFO_FULL_CNT);
	assign do_pop = pop && (cnt_ff != 5'h00);
	assign count = cnt_ff;
	// pointers and count
	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			wp_ff <= 4'h0;
			rp_ff <= 4'h0;
			cnt_ff <= 5'h00;
		end
		else
		begin
			if (do_push)
				wp_ff <= wp_ff + 4'h1;
			if (do_pop)
				rp_ff <= rp_ff + 4'h1;
			cnt_ff <= cnt_ff + {4'h0, do_push} - {4'h0, do_pop};
		end
	end
	// storage; pop address looks ahead so dout tracks the head
	fpf_mem u_mem
	(
		.clk(clk),
		.we(do_push),
		.waddr(wp_ff),
		.wdata(din),
		.raddr(do_pop ? rp_ff + 4'h1 : rp_ff),
		.rdata(dout)
	);
endmodule // fpf_fifo

/* verilog/fpf_core.sv */
`timescale 1ns/1ps
module fpf_core
	import fpf_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic DACK_N, // dma acknowledge, active low
	input wire logic IOR_N, // read strobe
	input wire logic IOW_N, // write strobe
	input wire logic TC_IN, // terminal count pin, polarity per mode
	input wire logic [7:0] DMA_WDATA, // byte from dma on write strobe
	output logic [7:0] DMA_RDATA, // byte to dma
	input wire logic CORE_PUSH, // core byte into fifo (reads)
	input wire logic [7:0] CORE_WDATA,
	input wire logic CORE_POP, // core takes byte (writes)
	output logic [7:0] CORE_RDATA,
	output logic [4:0] FIFO_COUNT,
	output logic CORE_RESET, // soft or hard reset to the core
	output logic FDC_IRQ, // fdc_interrupt_out level
	output logic FDC_IRQ_OE_N, // low while driven
	output logic DMA_REQUEST_OUT, // fdc_dma_request level
	output logic DMA_REQUEST_OE_N, // low while driven
	output logic DENSITY_SELECT, // density_select after polarity
	input wire logic HIGH_DENSITY, // core density request, true = high
	output logic TC_ACTIVE, // terminal count in true sense
	output logic ABNORMAL_END // host stopped mid-sector
);
	fpf_phase_t phase_ff; // controller phase
	fpf_mode_t mode; // decoded operating mode
	logic [2:0] ctrl_ff; // control register bits
	logic [15:0] cfg_ff; // configuration register
	logic [15:0] core_ff; // core control register
	logic [3:0] cnt_ff; // parameter / result byte counter
	logic rqm_ff; // request_for_master
	logic dio_ff; // transfer_direction_flag
	logic cb_ff; // command_busy
	logic irq_ff; // fdc_irq
	logic drq_ff; // fdc_dma_request
	logic [7:0] data_ff; // last command byte or bypass byte
	logic abn_ff; // abnormal termination seen
	logic soft_rst; // either software reset bit (held or pulse) to core
	logic wr_acc, rd_acc; // apb access strobes
	logic fifo_on; // fifo enabled and not bypassed
	logic [4:0] thr; // threshold 1..16
	logic dack; // acknowledge active
	logic tc; // terminal count in true sense
	logic dma_push, dma_pop, pio_push, pio_pop;
	logic dma_ok; // outputs enabled: second mode or dma enable bit
	logic svc_ff; // service window open: between threshold and full or empty
	assign wr_acc = PSEL && PENABLE && PWRITE;
	assign rd_acc = PSEL && PENABLE && !PWRITE;
	assign PREADY = 1'b1; // zero wait states
	assign PSLVERR = 1'b0;
	assign dack = !DACK_N;
	// mode decode
	always_comb
	begin
		if (cfg_ff[CFG_IDENT])
			mode = MODE_AT;
		else if (cfg_ff[CFG_ENC])
			mode = MODE_PS;
		else
			mode = MODE_M30;
	end
	// terminal count polarity: active low only in second mode
	assign tc = (mode == MODE_PS) ? !TC_IN : TC_IN;
	assign TC_ACTIVE = tc;
	// density: active high only in first mode
	assign DENSITY_SELECT = (mode == MODE_AT) ? HIGH_DENSITY : !HIGH_DENSITY;
	// dma enable ignored in second mode, outputs then always driven
	assign dma_ok = (mode == MODE_PS) || ctrl_ff[CTRL_DMA_EN];
	assign FDC_IRQ_OE_N = !dma_ok;
	assign DMA_REQUEST_OE_N = !dma_ok;
	assign FDC_IRQ = irq_ff;
	assign DMA_REQUEST_OUT = drq_ff;
	// held reset wins over the self-clearing one; both hit the core
	assign soft_rst = ctrl_ff[CTRL_HOLD_RST] || ctrl_ff[CTRL_PULSE_RST];
	assign CORE_RESET = soft_rst || !NRST;
	assign thr = {1'b0, cfg_ff[CFG_THR_LSB +: 4]} + 5'h01;
	// fifo only in execution after configure enabled it
	assign fifo_on = cfg_ff[CFG_FIFO_EN] && (phase_ff == PH_EXEC);
	// acknowledge selects the fifo without address decode
	assign dma_push = dack && !IOW_N && cfg_ff[CFG_DMA_MODE] && !core_ff[CORE_READ];
	assign dma_pop = dack && !IOR_N && cfg_ff[CFG_DMA_MODE] && core_ff[CORE_READ];
	assign pio_push = wr_acc && (PADDR == ADDR_DATA) && (phase_ff == PH_EXEC)
		&& !core_ff[CORE_READ];
	assign pio_pop = rd_acc && (PADDR == ADDR_DATA) && (phase_ff == PH_EXEC)
		&& core_ff[CORE_READ];
	// control register: pin reset sets held bit, pulse bit clears itself
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			ctrl_ff <= 3'b001;
		else if (wr_acc && PADDR == ADDR_CTRL)
			ctrl_ff <= PWDATA[2:0];
		else
			ctrl_ff[CTRL_PULSE_RST] <= 1'b0;
	end
	// configuration: pin reset loads CFG_RESET, soft reset clears fifo enable; timing lives in core
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			cfg_ff <= CFG_RESET;
		else if (soft_rst)
			cfg_ff[CFG_FIFO_EN] <= 1'b0;
		else if (wr_acc && PADDR == ADDR_CFG)
			cfg_ff <= PWDATA[15:0];
	end
	// core control: start is a one-cycle strobe
	always_ff @(posedge CLK)
	begin
		if (!NRST || soft_rst)
			core_ff <= 16'h0000;
		else if (wr_acc && PADDR == ADDR_CORE)
			core_ff <= PWDATA[15:0];
		else
		begin
			core_ff[CORE_START] <= 1'b0;
			core_ff[CORE_DONE] <= 1'b0;
		end
	end
	// fifo; flushed by any reset
	fpf_fifo u_fifo
	(
		.clk(CLK),
		.clr(!NRST || soft_rst),
		.push(fifo_on && (core_ff[CORE_READ] ? CORE_PUSH : (dma_push || pio_push))),
		.din(core_ff[CORE_READ] ? CORE_WDATA : (dma_push ? DMA_WDATA : PWDATA[7:0])),
		.pop(fifo_on && (core_ff[CORE_READ] ? (dma_pop || pio_pop) : CORE_POP)),
		.dout(CORE_RDATA),
		.count(FIFO_COUNT)
	);
	assign DMA_RDATA = fifo_on ? CORE_RDATA : data_ff;
	// bypass byte path used in command phase and byte mode
	always_ff @(posedge CLK)
	begin
		if (!NRST || soft_rst)
			data_ff <= 8'h00;
		else if (wr_acc && PADDR == ADDR_DATA)
			data_ff <= PWDATA[7:0];
		else if (!fifo_on && CORE_PUSH)
			data_ff <= CORE_WDATA;
		else if (!fifo_on && dma_push)
			data_ff <= DMA_WDATA;
	end
	// phase machine with byte counter and main status flags
	always_ff @(posedge CLK)
	begin
		if (!NRST || soft_rst)
		begin
			phase_ff <= PH_RST;
			cnt_ff <= 4'h0;
			rqm_ff <= 1'b0;
			dio_ff <= 1'b0;
			cb_ff <= 1'b0;
		end
		else
		begin
			case (phase_ff)
				PH_RST:
				begin
					phase_ff <= PH_CMD; // idle, ready for a command
					rqm_ff <= 1'b1;
					dio_ff <= 1'b0;
				end
				PH_CMD:
				begin
					if (wr_acc && PADDR == ADDR_DATA && rqm_ff && !dio_ff)
					begin
						rqm_ff <= 1'b0;
						cb_ff <= 1'b1;
						cnt_ff <= cnt_ff + 4'h1;
					end
					else if (core_ff[CORE_ILLEGAL])
					begin
						rqm_ff <= 1'b0; // low for one cycle; invalid command goes to result phase
						phase_ff <= PH_RES;
						cnt_ff <= 4'h0;
					end
					else if (cb_ff && !rqm_ff)
					begin
						// byte processed: more params re-raise, last one leaves
						if (cnt_ff > core_ff[CORE_NPAR_LSB +: 4])
						begin
							phase_ff <= PH_EXEC;
							cnt_ff <= 4'h0;
						end
						else
							rqm_ff <= 1'b1;
					end
				end
				PH_EXEC:
				begin
					dio_ff <= core_ff[CORE_READ];
					if (core_ff[CORE_DONE])
					begin
						phase_ff <= PH_RES;
						rqm_ff <= 1'b1;
						dio_ff <= 1'b1;
					end
					else
						rqm_ff <= irq_ff && !cfg_ff[CFG_DMA_MODE];
				end
				PH_RES:
				begin
					rqm_ff <= 1'b1;
					dio_ff <= 1'b1;
					if (rd_acc && PADDR == ADDR_DATA && rqm_ff && dio_ff)
					begin
						if (cnt_ff + 4'h1 >= core_ff[CORE_NRES_LSB +: 4])
						begin
							phase_ff <= PH_CMD;
							dio_ff <= 1'b0;
							cb_ff <= 1'b0;
							cnt_ff <= 4'h0;
						end
						else
							cnt_ff <= cnt_ff + 4'h1;
					end
				end
				default:
					phase_ff <= PH_RST;
			endcase
		end
	end
	// pio service interrupt / result interrupt
	always_ff @(posedge CLK)
	begin
		if (!NRST || soft_rst)
			irq_ff <= 1'b0;
		else if (phase_ff == PH_EXEC && core_ff[CORE_DONE])
			irq_ff <= 1'b1;
		else if (phase_ff == PH_RES && rd_acc && PADDR == ADDR_DATA)
			irq_ff <= 1'b0;
		else if (phase_ff == PH_EXEC && !cfg_ff[CFG_DMA_MODE])
		begin
			if (!fifo_on)
				irq_ff <= core_ff[CORE_READ] ? CORE_PUSH || irq_ff && !pio_pop
					: !pio_push;
			else if (core_ff[CORE_READ])
			begin
				if (FIFO_COUNT >= FIFO_FULL_CNT - thr || core_ff[CORE_LAST] && FIFO_COUNT != 5'h00)
					irq_ff <= 1'b1;
				else if (FIFO_COUNT == 5'h00)
					irq_ff <= 1'b0;
			end
			else
			begin
				if (FIFO_COUNT == FIFO_FULL_CNT || (tc == 1'b0 && DACK_N && core_ff[CORE_LAST]))
					irq_ff <= 1'b0;
				else if (FIFO_COUNT <= thr)
					irq_ff <= 1'b1;
			end
		end
		else if (phase_ff == PH_CMD && core_ff[CORE_ILLEGAL])
			irq_ff <= 1'b1;
	end
	// service window; remembered so a single-mode drop on ack is only a gap, not the end
	always_ff @(posedge CLK)
	begin
		if (!NRST || soft_rst || phase_ff != PH_EXEC || !cfg_ff[CFG_DMA_MODE] || !fifo_on)
			svc_ff <= 1'b0;
		else if (tc && dack)
			svc_ff <= 1'b0;
		else if (core_ff[CORE_READ])
		begin
			if (FIFO_COUNT >= FIFO_FULL_CNT - thr || core_ff[CORE_LAST] && FIFO_COUNT != 5'h00)
				svc_ff <= 1'b1;
			else if (FIFO_COUNT == 5'h00)
				svc_ff <= 1'b0;
		end
		else
		begin
			if (FIFO_COUNT == FIFO_FULL_CNT)
				svc_ff <= 1'b0;
			else if (FIFO_COUNT <= thr)
				svc_ff <= 1'b1;
		end
	end
	// dma request, single or burst, fifo thresholds
	always_ff @(posedge CLK)
	begin
		if (!NRST || soft_rst || phase_ff != PH_EXEC || !cfg_ff[CFG_DMA_MODE])
			drq_ff <= 1'b0;
		else if (core_ff[CORE_START])
			drq_ff <= !core_ff[CORE_READ];
		else if (tc && dack)
			drq_ff <= 1'b0;
		else if (core_ff[CORE_LAST] && (dack || !IOR_N) && FIFO_COUNT <= 5'h01
			&& core_ff[CORE_READ])
			drq_ff <= 1'b0;
		else if (!fifo_on)
			// byte mode; verify pseudo read completes on acknowledge alone
			drq_ff <= core_ff[CORE_READ] ? (CORE_PUSH || drq_ff && !dack)
				: (cfg_ff[CFG_BURST_N] ? !dack : 1'b1);
		else if (core_ff[CORE_READ])
		begin
			if (FIFO_COUNT >= FIFO_FULL_CNT - thr || core_ff[CORE_LAST] && FIFO_COUNT != 5'h00)
				drq_ff <= !(cfg_ff[CFG_BURST_N] && dack);
			else if (FIFO_COUNT == 5'h00)
				drq_ff <= 1'b0;
			else if (svc_ff)
				drq_ff <= !(cfg_ff[CFG_BURST_N] && dack);
		end
		else
		begin
			if (FIFO_COUNT == FIFO_FULL_CNT || cfg_ff[CFG_BURST_N] && dack)
				drq_ff <= 1'b0;
			else if (FIFO_COUNT <= thr || svc_ff)
				drq_ff <= 1'b1;
		end
	end
	// host stop mid-sector gives abnormal status
	always_ff @(posedge CLK)
	begin
		if (!NRST || soft_rst || core_ff[CORE_START])
			abn_ff <= 1'b0;
		else if (phase_ff == PH_EXEC && core_ff[CORE_DONE] && !core_ff[CORE_LAST])
			abn_ff <= 1'b1;
	end
	assign ABNORMAL_END = abn_ff;
	// apb read mux
	always_comb
	begin
		PRDATA = 32'h0000_0000;
		case (PADDR)
			ADDR_CTRL: PRDATA = {29'h0, ctrl_ff};
			ADDR_CFG: PRDATA = {16'h0, cfg_ff};
			ADDR_STAT: PRDATA = {24'h0, rqm_ff, dio_ff, 1'b0, cb_ff, FIFO_COUNT[3:0]};
			ADDR_DATA: PRDATA = {24'h0, fifo_on ? CORE_RDATA : data_ff};
			ADDR_CORE: PRDATA = {16'h0, core_ff};
			default: PRDATA = 32'h0000_0000;
		endcase
	end
endmodule // fpf_core

/* tb/fpf_chk.sv */
`timescale 1ns/1ps
module fpf_chk
	import fpf_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic DACK_N,
	input wire logic TC_IN,
	input wire logic HIGH_DENSITY,
	input wire logic CORE_RESET,
	input wire logic [4:0] FIFO_COUNT,
	input wire logic FDC_IRQ_OE_N,
	input wire logic DMA_REQUEST_OUT,
	input wire logic DMA_REQUEST_OE_N,
	input wire logic DENSITY_SELECT,
	input wire logic TC_ACTIVE
);
	logic wr; // bus write lands
	logic ps; // second mode
	logic held_ff; // held reset copy
	logic [15:0] cfg_ff; // config copy
	assign wr = PSEL && PENABLE && PWRITE;
	assign ps = !cfg_ff[CFG_IDENT] && cfg_ff[CFG_ENC];
	// config copy, changed only by bus write or pin reset
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			cfg_ff <= CFG_RESET;
		else if (wr && PADDR == ADDR_CTRL + 8'h04)
			cfg_ff <= PWDATA[15:0];
	end
	// pin reset sets the held bit; only software clears it
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			held_ff <= 1'h1;
		else if (wr && PADDR == ADDR_CTRL)
			held_ff <= PWDATA[CTRL_HOLD_RST];
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	AST_PIN_HELD: assert property ($rose(NRST) |-> CORE_RESET)
		else $error("core free after pin reset");
	AST_HELD: assert property (held_ff |-> CORE_RESET)
		else $error("held reset not holding");
	AST_PULSE: assert property (wr && PADDR == ADDR_CTRL && PWDATA[1:0] == 2'h2
		|=> CORE_RESET ##[1:2] !CORE_RESET)
		else $error("pulse reset not self clearing");
	AST_FIFO_CLR: assert property (CORE_RESET [*2] |-> FIFO_COUNT == 5'h00)
		else $error("fifo kept data in reset");
	AST_DENS: assert property (DENSITY_SELECT == (HIGH_DENSITY ^ !cfg_ff[CFG_IDENT]))
		else $error("density polarity wrong");
	AST_TC: assert property (TC_ACTIVE == (TC_IN ^ ps))
		else $error("terminal count polarity wrong");
	AST_DRIVEN: assert property (ps |-> !FDC_IRQ_OE_N && !DMA_REQUEST_OE_N)
		else $error("outputs floating in second mode");
	AST_SINGLE: assert property (cfg_ff[CFG_BURST_N] && DMA_REQUEST_OUT && !DACK_N
		|-> ##[1:3] !DMA_REQUEST_OUT)
		else $error("single request held past ack");
	AST_TC_DROP: assert property (TC_ACTIVE && !DACK_N |-> ##[1:2] !DMA_REQUEST_OUT)
		else $error("request kept after terminal count");
	cover property (wr && PADDR == ADDR_CTRL && PWDATA[CTRL_PULSE_RST]);
	cover property (DMA_REQUEST_OUT && !DACK_N);
	cover property (FIFO_COUNT == FIFO_FULL_CNT);
endmodule // fpf_chk
bind fpf_core fpf_chk i_fpf_chk (.*);

/* tb/fpf_isa_dma.sv */
`timescale 1ns/1ps
module fpf_isa_dma
	import fpf_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic req,
	input wire logic hold, // stall: no service
	input wire logic tc_next, // next cycle carries tc
	input wire logic force_tc, // raw pin drive
	output logic dack_n,
	output logic iow_n,
	output logic ior_n,
	output logic tc_pin,
	output logic [7:0] wdata
);
	logic [1:0] st_ff; // 0 idle, 1 strobe, 2 recovery
	logic [7:0] byte_ff; // byte to hand over
	logic tc_ff; // tc rides on this cycle
	assign dack_n = st_ff != 2'h1;
	assign iow_n = st_ff != 2'h1;
	assign ior_n = 1'h1; // writes only
	// released lines show the inverse so a stale byte never looks fresh
	assign wdata = dack_n ? ~byte_ff : byte_ff;
	assign tc_pin = force_tc || (tc_ff && !dack_n);
	// one strobe per sampled request, then a recovery clock
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			st_ff <= 2'h0;
			byte_ff <= 8'hA0;
			tc_ff <= 1'h0;
		end
		else if (st_ff == 2'h0 && req && !hold)
		begin
			st_ff <= 2'h1;
			tc_ff <= tc_next;
		end
		else if (st_ff == 2'h1)
		begin
			st_ff <= 2'h2;
			byte_ff <= byte_ff + 8'h01;
		end
		else
			st_ff <= 2'h0;
	end
endmodule // fpf_isa_dma

/* tb/floppy_ctrl_phase_and_fifo_flow_test.sv */
`timescale 1ns/1ps
module floppy_ctrl_phase_and_fifo_flow_test
	import fpf_pkg::*;
;
	typedef struct packed
	{
		logic [7:0] cfg;
		logic [2:0] ctrl;
		logic hd;
		logic tc;
		logic dens;
		logic tca;
	} fpf_row_t;
	logic CLK = 1'h0;
	logic NRST = 1'h0;
	logic PSEL = 1'h0;
	logic PENABLE = 1'h0;
	logic PWRITE = 1'h0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0000_0000;
	logic [31:0] PRDATA;
	logic PREADY, PSLVERR, DACK_N, IOR_N, IOW_N, TC_IN;
	logic [7:0] DMA_WDATA, DMA_RDATA, CORE_RDATA;
	logic CORE_PUSH = 1'h0, CORE_POP = 1'h0, HIGH_DENSITY = 1'h0;
	logic [7:0] CORE_WDATA = 8'h00;
	logic [4:0] FIFO_COUNT;
	logic CORE_RESET, FDC_IRQ, FDC_IRQ_OE_N, DMA_REQUEST_OUT, DMA_REQUEST_OE_N;
	logic DENSITY_SELECT, TC_ACTIVE, ABNORMAL_END;
	logic hold = 1'h1, tc_next = 1'h0, force_tc = 1'h0; // partner controls
	logic [31:0] rdat; // last read data
	int failures = 0, num_checks = 0, cyc = 0, n;
	// mode rows: cfg, ctrl, density in, tc pin, expected density, expected tc
	fpf_row_t rows [6] = '{
		'{8'h08, 3'h4, 1'h1, 1'h1, 1'h1, 1'h1},
		'{8'h0C, 3'h4, 1'h0, 1'h0, 1'h0, 1'h0},
		'{8'h04, 3'h0, 1'h1, 1'h0, 1'h0, 1'h1},
		'{8'h04, 3'h0, 1'h0, 1'h1, 1'h1, 1'h0},
		'{8'h00, 3'h4, 1'h1, 1'h1, 1'h0, 1'h1},
		'{8'h00, 3'h4, 1'h0, 1'h0, 1'h1, 1'h0}};
	fpf_core i_fpf_core (.*);
	fpf_isa_dma i_fpf_isa_dma (.clk(CLK), .nrst(NRST), .req(DMA_REQUEST_OUT),
		.hold(hold), .tc_next(tc_next), .force_tc(force_tc), .dack_n(DACK_N),
		.iow_n(IOW_N), .ior_n(IOR_N), .tc_pin(TC_IN), .wdata(DMA_WDATA));
	// 20 MHz clock
	always #25 CLK = ~CLK;
	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// hang guard, far above the few hundred cycles needed
	always @(posedge CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			failures++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t got %0h want %0h", $time, got, exp);
		end
	endtask
	// one bus transfer; read data taken at the rising edge that samples pready high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'h1;
		PENABLE <= 1'h0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'h1;
		@(posedge CLK);
		while (PREADY !== 1'h1)
			@(posedge CLK);
		rdat = PRDATA;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
	endtask
	initial
	begin
		repeat (8) @(posedge CLK);
		NRST <= 1'h1;
		apb(1'h0, ADDR_CTRL, 32'h0000_0000);
		chk(rdat, 32'h0000_0001);
		apb(1'h0, ADDR_CFG, 32'h0000_0000);
		chk(rdat, 32'h0000_0002);
		apb(1'h0, 8'h40, 32'h0000_0000);
		chk(rdat, 32'h0000_0000);
		chk(CORE_RESET, 1'h1);
		apb(1'h1, ADDR_CTRL, 32'h0000_0006);
		@(negedge CLK);
		chk(CORE_RESET, 1'h1);
		repeat (2) @(negedge CLK);
		chk(CORE_RESET, 1'h0);
		chk(FIFO_COUNT, 5'h00);
		apb(1'h0, ADDR_CTRL, 32'h0000_0000);
		chk(rdat, 32'h0000_0004);
		apb(1'h1, ADDR_CTRL, 32'h0000_0007);
		repeat (4) @(negedge CLK);
		chk(CORE_RESET, 1'h1);
		foreach (rows[i])
		begin
			apb(1'h1, ADDR_CTRL, {29'h0000_0000, rows[i].ctrl});
			apb(1'h1, ADDR_CFG, {24'h00_0000, rows[i].cfg});
			HIGH_DENSITY <= rows[i].hd;
			force_tc <= rows[i].tc;
			@(negedge CLK);
			chk(DENSITY_SELECT, rows[i].dens);
			chk(TC_ACTIVE, rows[i].tca);
			chk({FDC_IRQ_OE_N, DMA_REQUEST_OE_N}, 2'h0);
		end
		force_tc <= 1'h0;
		apb(1'h1, ADDR_CTRL, 32'h0000_0004);
		apb(1'h1, ADDR_CFG, 32'h0000_131A);
		apb(1'h1, ADDR_CORE, 32'h0000_1100);
		apb(1'h0, ADDR_STAT, 32'h0000_0000);
		chk(rdat[7:6], 2'h2);
		apb(1'h1, ADDR_DATA, 32'h0000_0045);
		apb(1'h0, ADDR_STAT, 32'h0000_0000);
		chk(rdat[7:6], 2'h2);
		hold <= 1'h0;
		apb(1'h1, ADDR_DATA, 32'h0000_0001);
		apb(1'h0, ADDR_STAT, 32'h0000_0000);
		chk(rdat[7], 1'h0);
		n = 0;
		while (FIFO_COUNT !== FIFO_FULL_CNT && n < 300)
		begin
			@(posedge CLK);
			n++;
		end
		hold <= 1'h1;
		repeat (3) @(negedge CLK);
		chk({FIFO_COUNT, DMA_REQUEST_OUT}, {FIFO_FULL_CNT, 1'h0});
		for (int k = 0; k < 12; k++)
		begin
			@(negedge CLK);
			chk(CORE_RDATA, 8'hA0 + k);
			if (k == 11)
				chk(DMA_REQUEST_OUT, 1'h0);
			@(posedge CLK);
			CORE_POP <= 1'h1;
			@(posedge CLK);
			CORE_POP <= 1'h0;
		end
		repeat (3) @(negedge CLK);
		chk(DMA_REQUEST_OUT, 1'h1);
		@(posedge CLK);
		tc_next <= 1'h1;
		hold <= 1'h0;
		repeat (8) @(negedge CLK);
		chk({FIFO_COUNT, DMA_REQUEST_OUT}, {5'h05, 1'h0});
		apb(1'h1, ADDR_CORE, 32'h0000_1110);
		apb(1'h0, ADDR_STAT, 32'h0000_0000);
		chk(rdat[7:6], 2'h3);
		chk(ABNORMAL_END, 1'h1);
		@(negedge CLK);
		chk(FDC_IRQ, 1'h1);
		apb(1'h0, ADDR_DATA, 32'h0000_0000);
		apb(1'h0, ADDR_STAT, 32'h0000_0000);
		chk({rdat[7:6], rdat[4]}, 3'h4);
		summarize();
	end
endmodule // floppy_ctrl_phase_and_fifo_flow_test
